// ### rtl/adc_regs_pkg.sv
package adc_regs_pkg;
    localparam logic [7:0] ctrl_addr = 8'h20;
    localparam logic [7:0] converter_mode_addr = 8'h21;
    localparam logic [7:0] conversion_result_high_addr = 8'h22;
    localparam logic [7:0] conversion_result_low_addr = 8'h23;
    localparam logic [7:0] reference_select_addr = 8'h24;
    localparam int ctrl_enable_bit = 7;
    localparam int ctrl_start_bit = 6;
    localparam int ctrl_chan_lsb = 2;
    localparam int mode_div_lsb = 1;
    localparam int ref_ext_bit = 7;
    localparam logic [2:0] div_reset = 3'h0;
    localparam logic [3:0] chan_reset = 4'h0;
    localparam logic [3:0] chan_last_ext = 4'hc;
    localparam logic [3:0] chan_bandgap = 4'hf;
    localparam int result_bits = 12;
    localparam logic [7:0] div_count_reset = 8'h00;
endpackage

// ### rtl/conv_clk_if.sv
`timescale 1ns/1ps
interface conv_clk_if;
    logic [2:0] div_sel;
    logic tick;
    modport src (input div_sel, output tick);
    modport dst (output div_sel, input tick);
endinterface

// ### rtl/conv_clk_div.sv
`timescale 1ns/1ps
module conv_clk_div (
    input wire logic sys_clk,
    input wire logic sys_rst,
    conv_clk_if.src clk_bus
);
    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } div_s;
    div_s cur, nxt;
    logic [7:0] terminal;
    always_comb begin
        terminal = 8'(({8'h00, 1'b1} << clk_bus.div_sel) - 9'h001);
        nxt = cur;
        if (cur.count >= terminal) begin
            nxt.count = adc_regs_pkg::div_count_reset;
            nxt.tick = 1'b1;
        end else begin
            nxt.count = cur.count + 8'h01;
            nxt.tick = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end
    assign clk_bus.tick = cur.tick;
endmodule

// ### rtl/adc_ctrl_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - converter clock is sys_clk over two-power mode
// - high result holds bits eleven to four
// - result left-aligned, msb at bit seven
// - low result upper nibble holds bits three-zero
// - reference bit seven picks supply or pin
// - control bit seven enables the converter
// - write one starts if already enabled; reads one unless converting
// - control bits five-two select analog input
module adc_ctrl_regs #(
    parameter int conv_ticks = 14
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic conv_enable,
    output logic conv_sample,
    output logic [3:0] chan_select,
    output logic ref_external,
    output logic conv_clk_tick,
    input wire logic conv_bit
);
    typedef enum logic [1:0] {st_idle, st_conv, st_done} state_e;
    typedef struct packed {
        state_e state;
        logic enable;
        logic [3:0] chan;
        logic [2:0] div;
        logic ref_ext;
        logic [11:0] shift;
        logic [11:0] result;
        logic [4:0] bit_cnt;
        logic [7:0] rdata;
        logic sample;
        logic tick;
        logic bit_s1;
        logic bit_s2;
    } regs_s;
    regs_s cur, next_cur;
    conv_clk_if clk_bus ();
    conv_clk_div u_div (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_bus(clk_bus)
    );
    assign clk_bus.div_sel = cur.div;
    logic start_wr;
    logic done_flag;
    always_comb begin
        next_cur = cur;
        next_cur.bit_s1 = conv_bit;
        next_cur.bit_s2 = cur.bit_s1;
        next_cur.tick = clk_bus.tick;
        next_cur.sample = 1'b0;
        start_wr = io_wr && io_addr == adc_regs_pkg::ctrl_addr
            && io_wdata[adc_regs_pkg::ctrl_start_bit];
        done_flag = cur.state != st_conv;
        if (io_wr) begin
            if (io_addr == adc_regs_pkg::ctrl_addr) begin
                next_cur.enable = io_wdata[adc_regs_pkg::ctrl_enable_bit];
                next_cur.chan = io_wdata[adc_regs_pkg::ctrl_chan_lsb +: 4];
            end else if (io_addr == adc_regs_pkg::converter_mode_addr) begin
                next_cur.div = io_wdata[adc_regs_pkg::mode_div_lsb +: 3];
            end else if (io_addr == adc_regs_pkg::reference_select_addr) begin
                next_cur.ref_ext = io_wdata[adc_regs_pkg::ref_ext_bit];
            end
        end
        case (cur.state)
            st_idle, st_done: begin
                if (start_wr && cur.enable) begin
                    next_cur.state = st_conv;
                    next_cur.bit_cnt = 5'h00;
                    next_cur.shift = 12'h000;
                end
            end
            st_conv: begin
                if (!cur.enable) begin
                    next_cur.state = st_idle;
                end else if (cur.tick) begin
                    if (cur.bit_cnt == 5'(conv_ticks - 1)) begin
                        next_cur.state = st_done;
                        next_cur.result = cur.shift;
                    end else begin
                        next_cur.bit_cnt = cur.bit_cnt + 5'h01;
                        if (cur.bit_cnt < 5'(adc_regs_pkg::result_bits)) begin
                            next_cur.shift = {cur.shift[10:0], cur.bit_s2};
                            next_cur.sample = 1'b1;
                        end
                    end
                end
            end
            default: next_cur.state = st_idle;
        endcase
        next_cur.rdata = 8'h00;
        if (io_rd) begin
            if (io_addr == adc_regs_pkg::ctrl_addr) begin
                next_cur.rdata = {cur.enable, done_flag, cur.chan, 2'h0};
            end else if (io_addr == adc_regs_pkg::converter_mode_addr) begin
                next_cur.rdata = {4'h0, cur.div, 1'b0};
            end else if (io_addr == adc_regs_pkg::conversion_result_high_addr) begin
                next_cur.rdata = cur.result[11:4];
            end else if (io_addr == adc_regs_pkg::conversion_result_low_addr) begin
                next_cur.rdata = {cur.result[3:0], 4'h0};
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur <= '0;
            cur.state <= st_idle;
            cur.div <= adc_regs_pkg::div_reset;
            cur.chan <= adc_regs_pkg::chan_reset;
        end else begin
            cur <= next_cur;
        end
    end
    assign io_rdata = cur.rdata;
    assign conv_enable = cur.enable;
    assign conv_sample = cur.sample;
    assign chan_select = cur.chan;
    assign ref_external = cur.ref_ext;
    assign conv_clk_tick = cur.tick;

    a_result_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cur.state != st_conv |=> $stable(cur.result))
        else $error("result changed outside conversion");
    a_high_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::conversion_result_high_addr
        |=> io_rdata == $past(cur.result[11:4]))
        else $error("high result read wrong");
    a_low_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::conversion_result_low_addr
        |=> io_rdata[3:0] == 4'h0 && io_rdata[7:4] == $past(cur.result[3:0]))
        else $error("low result read wrong");
    a_enable_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !conv_enable && cur.state != st_conv |=> cur.state != st_conv)
        else $error("conversion started while disabled");
    a_done_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::ctrl_addr && cur.state != st_conv
        |=> io_rdata[6])
        else $error("done bit not reported");
    a_ref_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr && io_addr == adc_regs_pkg::reference_select_addr
        |=> ref_external == $past(io_wdata[7]))
        else $error("reference select not stored");
    a_chan_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr && io_addr == adc_regs_pkg::ctrl_addr |=> chan_select == $past(io_wdata[5:2]))
        else $error("channel not stored");
    a_div_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cur.div == 3'h1 && $past(cur.div) == 3'h1 && $past(cur.div, 2) == 3'h1
        && conv_clk_tick && !io_wr |=> !conv_clk_tick)
        else $error("divide by two ticked twice");
    a_mode_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::converter_mode_addr |=> io_rdata[7:4] == 4'h0)
        else $error("reserved mode bits set");
    c_conv_done: cover property (@(posedge sys_clk) cur.state == st_conv ##1 cur.state == st_done);
    c_abort: cover property (@(posedge sys_clk) cur.state == st_conv && !cur.enable);
    c_slow_div: cover property (@(posedge sys_clk) cur.div == 3'h7 && conv_clk_tick);
    c_busy_read: cover property (@(posedge sys_clk) cur.state == st_conv && io_rd);
    c_ext_ref: cover property (@(posedge sys_clk) ref_external && cur.state == st_done);

    // sequencer guards
    a_abort_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cur.state == st_conv && !cur.enable
        |=> cur.state == st_idle)
        else $error("abort did not return to idle");
    a_result_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cur.state == st_conv && cur.enable && cur.tick && cur.bit_cnt == 5'(conv_ticks - 1)
        |=> cur.result == $past(cur.shift))
        else $error("result not latched at end");
    a_done_state: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cur.state == st_conv && cur.enable && cur.tick && cur.bit_cnt == 5'(conv_ticks - 1)
        |=> cur.state == st_done)
        else $error("conversion did not finish");
    a_sample_tick: assert property (@(posedge sys_clk) disable iff (sys_rst)
        conv_sample
        |-> $past(cur.tick))
        else $error("sample without converter tick");
    a_high_wr_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr && io_addr == adc_regs_pkg::conversion_result_high_addr && cur.state != st_conv
        |=> $stable(cur.result))
        else $error("result changed by a write");

    // register read guards
    a_busy_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::ctrl_addr && cur.state == st_conv
        |=> !io_rdata[6])
        else $error("done bit set while converting");
    a_enable_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::ctrl_addr
        |=> io_rdata[7] == $past(cur.enable))
        else $error("enable bit read wrong");
    a_chan_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::ctrl_addr
        |=> io_rdata[5:2] == $past(cur.chan) && io_rdata[1:0] == 2'h0)
        else $error("channel read wrong");
    a_ref_wo: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::reference_select_addr
        |=> io_rdata == 8'h00)
        else $error("write-only reference readable");
    a_mode_lsb: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_rd && io_addr == adc_regs_pkg::converter_mode_addr
        |=> io_rdata[0] == 1'b0)
        else $error("reserved mode bit zero set");
    a_idle_rdata: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !io_rd
        |=> io_rdata == 8'h00)
        else $error("read data without read");

    // register write guards
    a_div_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr && io_addr == adc_regs_pkg::converter_mode_addr
        |=> cur.div == $past(io_wdata[3:1]))
        else $error("divider code not stored");
    a_enable_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_wr && io_addr == adc_regs_pkg::ctrl_addr
        |=> conv_enable == $past(io_wdata[7]))
        else $error("enable not stored");
endmodule

// ### testbench/adc_clock_result_reference_regs_test.sv
`timescale 1ns/1ps
module adc_clock_result_reference_regs_test;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] io_addr = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic conv_bit = 1'b0;
    logic [7:0] io_rdata;
    logic conv_enable, conv_sample, ref_external, conv_clk_tick;
    logic [3:0] chan_select;
    logic [7:0] rd;
    logic [11:0] last = 12'h000;
    int err_count = 0;
    int comparisons = 0;
    always #20 sys_clk = ~sys_clk;
    adc_ctrl_regs dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .conv_enable(conv_enable), .conv_sample(conv_sample), .chan_select(chan_select),
        .ref_external(ref_external), .conv_clk_tick(conv_clk_tick), .conv_bit(conv_bit));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge sys_clk);
        io_wr = 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(negedge sys_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge sys_clk);
        io_rd = 1'b0;
        rd = io_rdata;
    endtask
    // waits for a tick (sel 0) or a sample pulse (sel 1)
    task automatic wait_on(input int sel);
        int k;
        for (k = 0; k < 2000; k++) begin
            @(negedge sys_clk);
            if (((sel == 0) ? conv_clk_tick : conv_sample) === 1'b1) break;
        end
        if (k == 2000) check(8'h00, 8'h01);
    endtask
    task automatic period(input int c);
        int m;
        wait_on(0);
        wait_on(0);
        m = 0;
        do begin
            @(negedge sys_clk);
            m++;
        end while (conv_clk_tick !== 1'b1 && m < 300);
        check(8'(m), 8'(1 << c));
    endtask
    task automatic conversion(input logic [11:0] v, input logic [3:0] c, input bit old);
        int k;
        conv_bit = v[11];
        wr(adc_regs_pkg::ctrl_addr, {2'b10, c, 2'b00});
        wr(adc_regs_pkg::ctrl_addr, {2'b11, c, 2'b00});
        check({7'h00, conv_enable}, 8'h01);
        check({4'h0, chan_select}, {4'h0, c});
        rdr(adc_regs_pkg::ctrl_addr);
        check({7'h00, rd[6]}, 8'h00);
        rdr(adc_regs_pkg::conversion_result_high_addr);
        if (old) check(rd, last[11:4]);
        for (k = 10; k >= 0; k--) begin
            wait_on(1);
            conv_bit = v[k];
        end
        for (k = 0; k < 1000; k++) begin
            rdr(adc_regs_pkg::ctrl_addr);
            if (rd[6] === 1'b1) break;
        end
        check({7'h00, rd[6]}, 8'h01);
        wr(adc_regs_pkg::conversion_result_high_addr, ~v[11:4]);
        rdr(adc_regs_pkg::conversion_result_high_addr);
        check(rd, v[11:4]);
        rdr(adc_regs_pkg::conversion_result_low_addr);
        check(rd & 8'hf0, {v[3:0], 4'h0});
        last = v;
        $display("conversion of %h done", v);
    endtask
    initial begin
        #(20000 * 40);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude;
    end
    initial begin
        void'($urandom(41));
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        check({7'h00, conv_enable}, 8'h00);
        check({7'h00, ref_external}, 8'h00);
        rdr(adc_regs_pkg::ctrl_addr);
        check(rd & 8'hbc, 8'h00);
        rdr(8'h25);
        check(rd, 8'h00);
        wr(adc_regs_pkg::ctrl_addr, 8'h40);
        rdr(adc_regs_pkg::ctrl_addr);
        check({7'h00, rd[6]}, 8'h01);
        $display("reset test done");
        wr(adc_regs_pkg::ctrl_addr, 8'h80);
        period(0);
        for (int c = 0; c < 8; c++) begin
            wr(adc_regs_pkg::converter_mode_addr, {4'h0, 3'(c), 1'b0});
            period(c);
        end
        $display("divider test done");
        wr(adc_regs_pkg::reference_select_addr, 8'h80);
        check({7'h00, ref_external}, 8'h01);
        wr(adc_regs_pkg::reference_select_addr, 8'h00);
        check({7'h00, ref_external}, 8'h00);
        $display("reference test done");
        conversion(12'h801, adc_regs_pkg::chan_bandgap, 1'b0);
        conversion(12'h7fe, adc_regs_pkg::chan_last_ext, 1'b1);
        conversion(12'($urandom), 4'($urandom % 13), 1'b1);
        wr(adc_regs_pkg::ctrl_addr, 8'h00);
        check({7'h00, conv_enable}, 8'h00);
        conclude;
    end
endmodule
